//--- rtl/csh_cat_counter.sv
`timescale 1ns/1ps
module csh_cat_counter (
	input logic clk_i,
	input logic reset_i,
	csh_cnt_if.chk cnt
);
	import csh_pkg::*;

	csh_cnt_t cnt_q [NCAT];
	logic [NCAT-1:0] over_q;
	csh_cat_t last_cat;

	// One counter per category, cleared when a session opens
	genvar i;
	generate
		for (i = 0; i < NCAT; i++) begin : g_cat
			always_ff @(posedge clk_i) begin
				if (reset_i || cnt.clear) begin
					cnt_q[i] <= RST_COUNT;
					over_q[i] <= 1'b0;
				end else if (cnt.def_seen && cnt.def_cat == csh_cat_t'(i)) begin
					cnt_q[i] <= cnt_q[i] + 14'h0001;
					if (cnt_q[i] == cnt.announced[i]) begin
						over_q[i] <= 1'b1;
					end
				end
			end
			assign cnt.counts[i] = cnt_q[i];
			assign cnt.equal[i] = cnt_q[i] == cnt.announced[i];
		end
	endgenerate

	assign cnt.over_err = |over_q;

	// A definition of an earlier category after a later one breaks the order
	always_ff @(posedge clk_i) begin
		if (reset_i || cnt.clear) begin
			last_cat <= 3'h0;
			cnt.order_err <= 1'b0;
		end else if (cnt.def_seen) begin
			last_cat <= cnt.def_cat;
			if (cnt.def_cat < last_cat) begin
				cnt.order_err <= 1'b1;
			end
		end
	end
endmodule : csh_cat_counter

//--- rtl/csh_cnt_if.sv
`timescale 1ns/1ps
interface csh_cnt_if;
	import csh_pkg::*;
	logic clear;
	logic def_seen;
	csh_cat_t def_cat;
	csh_counts_t announced;
	csh_counts_t counts;
	logic [NCAT-1:0] equal;
	logic order_err;
	logic over_err;
	modport src(output clear, def_seen, def_cat, announced,
		input counts, equal, order_err, over_err);
	modport chk(input clear, def_seen, def_cat, announced,
		output counts, equal, order_err, over_err);
endinterface : csh_cnt_if

//--- rtl/csh_host_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Configuration names hold 1 to 16 characters and identify one configuration.
// - CURRENT and NEXT never name a stored configuration; monitoring only.
// - Creation starts with the session-open message carrying per-category counts.
// - Definitions go sub-channels, streams, components, services, FIG files.
// - Sender sends exactly the announced definitions, then the close message.
// - Only the opener of a session may close it.
// - The error message aborts an open session or reports other errors.
// - Sub-channel count ranges from 0 to 64.
// - Stream count ranges from 0 to 2047.
// - Component and service counts range from 0 to 9999.
// - FIG-file-use count ranges from 0 to 64.
// - Either side may request definitions and answer such requests; this controller only sends queries and ignores incoming ones.
module csh_host_ctrl #(
	parameter int REPLY_WAIT = csh_pkg::REPLY_WAIT_CYCLES
) (
	input logic clk_i,
	input logic reset_i,
	input logic [csh_pkg::ADDR_W-1:0] addr_i,
	input logic [csh_pkg::DATA_W-1:0] wdata_i,
	input logic wr_i,
	input logic rd_i,
	output logic [csh_pkg::DATA_W-1:0] rdata_o,
	output logic tx_valid_o,
	output csh_pkg::csh_msg_t tx_type_o,
	output logic [csh_pkg::NAME_W-1:0] tx_name_o,
	output logic [4:0] tx_name_len_o,
	output csh_pkg::csh_counts_t tx_counts_o,
	output csh_pkg::csh_cause_t tx_cause_o,
	input logic tx_ready_i,
	input logic rx_valid_i,
	input csh_pkg::csh_msg_t rx_type_i,
	input csh_pkg::csh_counts_t rx_counts_i,
	input csh_pkg::csh_cause_t rx_cause_i
);
	import csh_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_OPEN, ST_DEFS, ST_CLOSE, ST_REQ, ST_WAIT, ST_RX, ST_ERR
	} csh_state_t;

	csh_state_t state;
	logic [NAME_W-1:0] name_q;
	logic [4:0] name_len;
	csh_counts_t counts_q;
	csh_counts_t rx_counts_q;
	csh_cat_t cur_cat;
	logic [31:0] wait_cnt;
	logic done;
	logic err;
	logic rx_ok;
	csh_cause_t cause;
	logic tx_fire;
	logic ctrl_wr;
	logic sw_abort;
	logic idle_wr;
	logic name_ok;
	logic is_reserved;
	logic counts_ok;
	logic [NCAT-1:0] cnt_in_range;
	logic start_create;
	logic start_query;
	logic start_delete;
	logic cmd_reject;
	csh_cause_t reject_cause;
	logic rx_abort;
	logic rx_def;
	logic rx_close;
	logic rx_good_close;
	logic wait_expire;
	csh_cause_t rx_mismatch;
	logic [5:0] widx;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] rd_word;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	csh_cnt_if txc ();
	csh_cnt_if rxc ();

	// Counters of sent and of received definitions
	csh_cat_counter u_tx_cnt (.clk_i(clk_i), .reset_i(reset_i), .cnt(txc));
	csh_cat_counter u_rx_cnt (.clk_i(clk_i), .reset_i(reset_i), .cnt(rxc));

	// Link decode and command checks
	assign tx_fire = tx_valid_o && tx_ready_i;
	assign ctrl_wr = wr_i && addr_i == REG_CTRL;
	assign idle_wr = wr_i && state == ST_IDLE;
	assign sw_abort = ctrl_wr && wdata_i[CTRL_ABORT_BIT];
	assign name_ok = name_len >= NAME_LEN_MIN && name_len <= NAME_LEN_MAX;
	assign is_reserved = (name_len == NAME_CUR_LEN && name_q[55:0] == NAME_CURRENT)
		|| (name_len == NAME_NEXT_LEN && name_q[31:0] == NAME_NEXT);
	genvar i;
	generate
		for (i = 0; i < NCAT; i++) begin : g_range
			assign cnt_in_range[i] = counts_q[i] <= CNT_MAX[i];
		end
	endgenerate
	assign counts_ok = &cnt_in_range;
	assign start_create = ctrl_wr && state == ST_IDLE && wdata_i[1:0] == CMD_CREATE
		&& name_ok && !is_reserved && counts_ok;
	// Reserved names may be queried, never created or deleted
	assign start_query = ctrl_wr && state == ST_IDLE && wdata_i[1:0] == CMD_QUERY && name_ok;
	assign start_delete = ctrl_wr && state == ST_IDLE && wdata_i[1:0] == CMD_DELETE
		&& name_ok && !is_reserved;
	assign cmd_reject = ctrl_wr && state == ST_IDLE && wdata_i[1:0] != 2'h0
		&& !start_create && !start_query && !start_delete;
	assign reject_cause = (!name_ok || is_reserved) ? CAUSE_LOC_NAME : CAUSE_LOC_COUNT;
	assign rx_abort = rx_valid_i && rx_type_i == MSG_ERROR;
	assign rx_close = rx_valid_i && rx_type_i == MSG_CLOSE;
	assign rx_def = rx_valid_i && rx_type_i >= MSG_DEF_SUB && rx_type_i <= MSG_DEF_FIG;
	assign rx_good_close = state == ST_RX && rx_close && !rxc.order_err && !rxc.over_err
		&& &rxc.equal;
	assign wait_expire = state == ST_WAIT && !rx_valid_i && wait_cnt == 32'(REPLY_WAIT - 1);

	// Counter hookup: own definitions on the send side, the far end's on the receive side
	assign txc.clear = state == ST_OPEN && tx_fire;
	assign txc.def_seen = state == ST_DEFS && tx_fire;
	assign txc.def_cat = cur_cat;
	assign txc.announced = counts_q;
	assign rxc.clear = state == ST_WAIT && rx_valid_i && rx_type_i == MSG_OPEN;
	assign rxc.def_seen = state == ST_RX && rx_def;
	assign rxc.def_cat = csh_cat_t'(rx_type_i - MSG_DEF_SUB);
	assign rxc.announced = rx_counts_q;

	// Lowest category whose received count differs from the announced one
	always_comb begin
		rx_mismatch = CAUSE_NONE;
		for (int k = NCAT - 1; k >= 0; k--) begin
			if (!rxc.equal[k]) begin
				rx_mismatch = csh_cause_t'(5'(CAUSE_CNT_SUB) + 5'(k));
			end
		end
	end

	// Name, length and count registers; frozen while an operation runs
	generate
		for (i = 0; i < NAME_W / 32; i++) begin : g_name
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					name_q[i*32 +: 32] <= 32'h0000_0000;
				end else if (idle_wr && addr_i == REG_NAME0 + 8'(4 * i)) begin
					name_q[i*32 +: 32] <= wdata_i;
				end
			end
		end
		for (i = 0; i < NCAT; i++) begin : g_count
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					counts_q[i] <= RST_COUNT;
				end else if (idle_wr && addr_i == REG_COUNT0 + 8'(4 * i)) begin
					counts_q[i] <= wdata_i[CNT_W-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			name_len <= RST_NAME_LEN;
		end else if (idle_wr && addr_i == REG_NAME_LEN) begin
			name_len <= wdata_i[4:0];
		end
	end

	// Counts announced by the far end when it opens a session for our query
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_counts_q <= '0;
		end else if (rxc.clear) begin
			rx_counts_q <= rx_counts_i;
		end
	end

	assign tx_name_o = name_q;
	assign tx_name_len_o = name_len;
	assign tx_counts_o = counts_q;

	// Session sequencer and transmit message register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			tx_valid_o <= 1'b0;
			tx_type_o <= MSG_QUERY;
			tx_cause_o <= CAUSE_NONE;
			cur_cat <= 3'h0;
			wait_cnt <= 32'h0000_0000;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_create) begin
						tx_type_o <= MSG_OPEN;
						tx_valid_o <= 1'b1;
						state <= ST_OPEN;
					end else if (start_query || start_delete) begin
						tx_type_o <= start_query ? MSG_QUERY : MSG_DELETE;
						tx_valid_o <= 1'b1;
						state <= ST_REQ;
					end
				end
				ST_OPEN, ST_CLOSE: begin
					if (rx_abort) begin
						tx_valid_o <= 1'b0;
						state <= ST_IDLE;
					end else if (tx_fire) begin
						tx_valid_o <= 1'b0;
						cur_cat <= 3'h0;
						state <= (state == ST_OPEN) ? ST_DEFS : ST_IDLE;
					end
				end
				ST_DEFS: begin
					if (rx_abort) begin
						tx_valid_o <= 1'b0;
						state <= ST_IDLE;
					end else if (sw_abort || rx_close) begin
						tx_type_o <= MSG_ERROR;
						tx_cause_o <= CAUSE_PROTO;
						tx_valid_o <= 1'b1; // Replaces any definition not yet taken
						state <= ST_ERR;
					end else if (tx_fire) begin
						tx_valid_o <= 1'b0;
					end else if (!tx_valid_o) begin
						if (cur_cat == CAT_END) begin
							tx_type_o <= MSG_CLOSE;
							tx_valid_o <= 1'b1;
							state <= ST_CLOSE;
						end else if (txc.equal[cur_cat]) begin
							cur_cat <= cur_cat + 3'h1;
						end else begin
							tx_type_o <= csh_msg_t'(MSG_DEF_SUB + {1'b0, cur_cat});
							tx_valid_o <= 1'b1;
						end
					end
				end
				ST_REQ: begin
					if (rx_abort) begin
						tx_valid_o <= 1'b0;
						state <= ST_IDLE;
					end else if (tx_fire) begin
						tx_valid_o <= 1'b0;
						wait_cnt <= 32'h0000_0000;
						state <= (tx_type_o == MSG_QUERY) ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WAIT: begin
					wait_cnt <= wait_cnt + 32'h0000_0001;
					if (rx_abort || wait_expire) begin
						state <= ST_IDLE;
					end else if (rxc.clear) begin
						state <= ST_RX;
					end
				end
				ST_RX: begin
					if (rx_abort || rx_good_close) begin
						state <= ST_IDLE;
					end else if (rxc.order_err || rxc.over_err || rx_close || sw_abort) begin
						tx_type_o <= MSG_ERROR;
						tx_cause_o <= rxc.order_err ? CAUSE_ORDER
							: (sw_abort && !rx_close && !rxc.over_err) ? CAUSE_PROTO
							: rx_mismatch;
						tx_valid_o <= 1'b1;
						state <= ST_ERR;
					end
				end
				ST_ERR: begin
					if (tx_fire || rx_abort) begin
						tx_valid_o <= 1'b0;
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Sticky status; a new command clears it, an event in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			done <= 1'b0;
			err <= 1'b0;
			rx_ok <= 1'b0;
			cause <= CAUSE_NONE;
		end else begin
			if (ctrl_wr && state == ST_IDLE) begin
				done <= 1'b0;
				err <= 1'b0;
				rx_ok <= 1'b0;
				cause <= CAUSE_NONE;
			end
			if ((state == ST_CLOSE && tx_fire && !rx_abort) || rx_good_close
				|| (state == ST_REQ && tx_fire && tx_type_o == MSG_DELETE && !rx_abort)) begin
				done <= 1'b1;
			end
			if (rx_good_close) begin
				rx_ok <= 1'b1;
			end
			if (cmd_reject) begin
				err <= 1'b1;
				cause <= reject_cause;
			end
			if (wait_expire) begin
				err <= 1'b1;
				cause <= CAUSE_TIMEOUT;
			end
			if (tx_fire && tx_type_o == MSG_ERROR) begin
				err <= 1'b1;
				cause <= tx_cause_o;
			end
			if (rx_abort) begin
				err <= 1'b1;
				cause <= rx_cause_i;
			end
		end
	end

	// Register read mux
	assign widx = addr_i[7:2];
	always_comb begin
		status_word = '0;
		status_word[ST_BUSY_BIT] = state != ST_IDLE;
		status_word[ST_DONE_BIT] = done;
		status_word[ST_ERR_BIT] = err;
		status_word[ST_RXOK_BIT] = rx_ok;
		status_word[ST_CAUSE_LSB +: 5] = cause;
		status_word[ST_STATE_LSB +: 3] = state;
		rd_word = '0;
		if (addr_i[1:0] != 2'h0) begin
			rd_word = '0;
		end else if (addr_i == REG_STATUS) begin
			rd_word = status_word;
		end else if (addr_i == REG_NAME_LEN) begin
			rd_word = {27'h0000000, name_len};
		end else if (addr_i >= REG_NAME0 && addr_i < REG_NAME_LEN) begin
			rd_word = name_q[32 * 2'(widx - REG_NAME0[7:2]) +: 32];
		end else if (addr_i >= REG_COUNT0 && addr_i < REG_RX_COUNT0) begin
			rd_word = {18'h00000, counts_q[3'(widx - REG_COUNT0[7:2])]};
		end else if (addr_i >= REG_RX_COUNT0 && addr_i < REG_END) begin
			rd_word = {18'h00000, rxc.counts[3'(widx - REG_RX_COUNT0[7:2])]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0000_0000;
		end else begin
			rdata_o <= rd_i ? rd_word : 32'h0000_0000;
		end
	end

	// Checks on the transmitted message stream
	sequence s_open_fire;
		tx_fire && tx_type_o == MSG_OPEN;
	endsequence
	sequence s_def_fire;
		tx_fire && tx_type_o >= MSG_DEF_SUB && tx_type_o <= MSG_DEF_FIG;
	endsequence
	sequence s_query_fire;
		tx_fire && tx_type_o == MSG_QUERY;
	endsequence

	open_before_def_a: assert property (s_def_fire |-> state == ST_DEFS)
		else $error("definition sent outside an opened session");
	def_order_a: assert property (s_def_fire |=> !txc.order_err)
		else $error("definition sent out of category order");
	exact_count_a: assert property (tx_fire && tx_type_o == MSG_CLOSE |-> &txc.equal)
		else $error("session closed with counts unlike those announced");
	name_len_a: assert property ((s_open_fire or s_query_fire) |-> name_ok)
		else $error("message sent with illegal name length");
	reserved_name_a: assert property (s_open_fire |-> !is_reserved)
		else $error("reserved name used to create a configuration");
	count_range_a: assert property (s_open_fire |-> counts_ok)
		else $error("session opened with a count out of range");
	opener_close_a: assert property (tx_fire && tx_type_o == MSG_CLOSE |-> state == ST_CLOSE)
		else $error("close sent for a session not opened here");
	error_abort_a: assert property (tx_fire && tx_type_o == MSG_ERROR |=> state == ST_IDLE && !tx_valid_o)
		else $error("session still active after error message");
	query_wait_a: assert property (s_query_fire ##1 !rx_valid_i |-> state == ST_WAIT)
		else $error("query sent but no wait for its answer");
	rx_abort_a: assert property (rx_abort && state != ST_IDLE |=> state == ST_IDLE ##1 !tx_valid_o)
		else $error("far end error did not end the session");
endmodule : csh_host_ctrl

//--- rtl/csh_pkg.sv
package csh_pkg;
	// Sizes of the message fields
	localparam int NCAT = 5;
	localparam int NAME_CHARS = 16;
	localparam int NAME_W = NAME_CHARS * 8;
	localparam int CNT_W = 14;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Wait for the answer to a definition query, in clock cycles
	localparam int REPLY_WAIT_CYCLES = 200000;

	typedef logic [CNT_W-1:0] csh_cnt_t;
	typedef logic [NCAT-1:0][CNT_W-1:0] csh_counts_t;
	typedef logic [2:0] csh_cat_t;

	// Categories in definition order: sub-channel, stream, component, service, FIG file
	localparam csh_cat_t CAT_END = 3'h5;
	localparam csh_counts_t CNT_MAX = {14'h0040, 14'h270F, 14'h270F, 14'h07FF, 14'h0040};

	// Name length limits and the two monitoring-only names, first character in the low byte
	localparam logic [4:0] NAME_LEN_MIN = 5'h01;
	localparam logic [4:0] NAME_LEN_MAX = 5'h10;
	localparam logic [4:0] NAME_CUR_LEN = 5'h07;
	localparam logic [55:0] NAME_CURRENT = 56'h544E4552525543;
	localparam logic [4:0] NAME_NEXT_LEN = 5'h04;
	localparam logic [31:0] NAME_NEXT = 32'h5458454E;

	// Message kinds of the configuration group and its definition messages
	typedef enum logic [3:0] {
		MSG_QUERY = 4'h0, MSG_OPEN = 4'h1, MSG_CLOSE = 4'h2, MSG_DELETE = 4'h3,
		MSG_ERROR = 4'h4, MSG_DEF_SUB = 4'h5, MSG_DEF_STRM = 4'h6, MSG_DEF_COMP = 4'h7,
		MSG_DEF_SERV = 4'h8, MSG_DEF_FIG = 4'h9
	} csh_msg_t;

	// Error causes; the last four are raised locally by the controller
	typedef enum logic [4:0] {
		CAUSE_NONE = 5'h00, CAUSE_UNKNOWN = 5'h01, CAUSE_NOSPACE = 5'h02, CAUSE_USED = 5'h03,
		CAUSE_CNT_SUB = 5'h04, CAUSE_CNT_STRM = 5'h05, CAUSE_CNT_COMP = 5'h06,
		CAUSE_CNT_SERV = 5'h07, CAUSE_CNT_FIG = 5'h08, CAUSE_DEF_SUB = 5'h09,
		CAUSE_DEF_STRM = 5'h0A, CAUSE_DEF_COMP = 5'h0B, CAUSE_DEF_SERV = 5'h0C,
		CAUSE_DEF_FIG = 5'h0D, CAUSE_ORDER = 5'h0E, CAUSE_LOC_NAME = 5'h0F,
		CAUSE_LOC_COUNT = 5'h10, CAUSE_TIMEOUT = 5'h11, CAUSE_PROTO = 5'h12
	} csh_cause_t;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_NAME0 = 8'h08;
	localparam logic [7:0] REG_NAME_LEN = 8'h18;
	localparam logic [7:0] REG_COUNT0 = 8'h1C;
	localparam logic [7:0] REG_RX_COUNT0 = 8'h30;
	localparam logic [7:0] REG_END = 8'h44;

	// Control fields
	localparam logic [1:0] CMD_CREATE = 2'h1;
	localparam logic [1:0] CMD_QUERY = 2'h2;
	localparam logic [1:0] CMD_DELETE = 2'h3;
	localparam int CTRL_ABORT_BIT = 4;

	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_RXOK_BIT = 3;
	localparam int ST_CAUSE_LSB = 8;
	localparam int ST_STATE_LSB = 16;

	// Values after reset
	localparam logic [4:0] RST_NAME_LEN = 5'h00;
	localparam csh_cnt_t RST_COUNT = 14'h0000;
endpackage : csh_pkg

//--- test/csh_dev_model.sv
`timescale 1ns/1ps
module csh_dev_model #(
	parameter csh_pkg::csh_counts_t AIR = {14'h0000, 14'h0001, 14'h0001, 14'h0002, 14'h0003}
) (
	input logic clk_i,
	input logic reset_i,
	input logic tx_valid_i,
	input csh_pkg::csh_msg_t tx_type_i,
	input logic [csh_pkg::NAME_W-1:0] tx_name_i,
	input logic [4:0] tx_name_len_i,
	input csh_pkg::csh_counts_t tx_counts_i,
	input csh_pkg::csh_cause_t tx_cause_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output csh_pkg::csh_msg_t rx_type_o,
	output csh_pkg::csh_counts_t rx_counts_o,
	output csh_pkg::csh_cause_t rx_cause_o,
	input logic [1:0] mode_i,
	input logic slow_i,
	input logic pending_i,
	output logic bad_o,
	output logic [2:0] n_stored_o,
	output csh_pkg::csh_cause_t last_cause_o,
	output logic [15:0] n_fire_o
);
	import csh_pkg::*;
	logic [NAME_W-1:0] s_name [4];
	logic [4:0] s_len [4];
	csh_counts_t s_cnt [4];
	logic [3:0] s_use;
	logic [78:0] outq [$];
	logic sess, drop, gap;
	csh_counts_t ann, rcnt;
	logic [2:0] cat;
	logic [1:0] wcnt;
	logic [NAME_W-1:0] sname;
	logic [4:0] slen;
	wire fire = tx_valid_i && tx_ready_o;
	assign n_stored_o = 3'($countones(s_use));

	// Looks a name up in the store
	function automatic int find(input logic [NAME_W-1:0] n, input logic [4:0] l);
		find = -1;
		for (int j = 0; j < 4; j++) begin
			if (s_use[j] && s_name[j] == n && s_len[j] == l) find = j;
		end
	endfunction : find

	// Queues one message for the host
	function automatic void put(input csh_msg_t t, input csh_counts_t c, input csh_cause_t e);
		outq.push_back({e, c, t});
	endfunction : put

	// Describes a configuration as a session; modes 1..3 stay silent, drop one, go backwards
	function automatic void reply(input csh_counts_t c);
		int k;
		if (mode_i == 2'h1) return;
		put(MSG_OPEN, c, CAUSE_NONE);
		for (int j = 0; j < NCAT; j++) begin
			k = (mode_i == 2'h3) ? NCAT - 1 - j : j;
			for (int n = int'(mode_i == 2'h2 && k == 0); n < int'(c[k]); n++) begin
				put(csh_msg_t'(int'(MSG_DEF_SUB) + k), '0, CAUSE_NONE);
			end
		end
		put(MSG_CLOSE, '0, CAUSE_NONE);
	endfunction : reply

	// Takes host messages, keeps the store and plays replies back with one idle cycle between them
	always @(posedge clk_i) begin : mdl
		int i, f, k;
		logic [78:0] w;
		if (reset_i) begin
			s_use <= '0;
			sess <= 1'b0;
			drop <= 1'b0;
			gap <= 1'b0;
			bad_o <= 1'b0;
			wcnt <= 2'h0;
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_type_o <= MSG_QUERY;
			rx_counts_o <= '0;
			rx_cause_o <= CAUSE_NONE;
			last_cause_o <= CAUSE_NONE;
			n_fire_o <= 16'h0000;
			outq.delete();
		end else begin
			rx_valid_o <= 1'b0;
			gap <= 1'b0;
			// Idle payload toggles so a stale value never looks like a message
			rx_type_o <= csh_msg_t'(~rx_type_o);
			rx_counts_o <= ~rx_counts_o;
			rx_cause_o <= csh_cause_t'(~rx_cause_o);
			if (!gap && outq.size() > 0) begin
				w = outq.pop_front();
				rx_valid_o <= 1'b1;
				rx_type_o <= csh_msg_t'(w[3:0]);
				rx_counts_o <= w[73:4];
				rx_cause_o <= csh_cause_t'(w[78:74]);
				gap <= 1'b1;
			end
			// Slow mode holds ready back for a few cycles
			wcnt <= (tx_valid_i && !fire) ? wcnt + 2'h1 : 2'h0;
			tx_ready_o <= tx_valid_i && !fire && (!slow_i || wcnt == 2'h3);
			if (fire) begin
				n_fire_o <= n_fire_o + 16'h0001;
				i = find(tx_name_i, tx_name_len_i);
				k = int'(tx_type_i) - int'(MSG_DEF_SUB);
				case (tx_type_i)
					MSG_OPEN: begin
						if (tx_name_len_i < NAME_LEN_MIN || tx_name_len_i > NAME_LEN_MAX) bad_o <= 1'b1;
						if (i >= 0) begin
							put(MSG_ERROR, '0, CAUSE_USED);
							drop <= 1'b1;
						end else begin
							sess <= 1'b1;
							drop <= 1'b0;
							cat <= 3'h0;
							rcnt <= '0;
							ann <= tx_counts_i;
							sname <= tx_name_i;
							slen <= tx_name_len_i;
						end
					end
					MSG_DEF_SUB, MSG_DEF_STRM, MSG_DEF_COMP, MSG_DEF_SERV, MSG_DEF_FIG: begin
						if (!drop && (!sess || 3'(k) < cat)) bad_o <= 1'b1;
						cat <= 3'(k);
						rcnt[k] <= rcnt[k] + 14'h0001;
					end
					MSG_CLOSE: begin
						f = -1;
						for (int j = 3; j >= 0; j--) if (!s_use[j]) f = j;
						if (!drop && (!sess || rcnt != ann || f < 0)) bad_o <= 1'b1;
						else if (!drop) begin
							s_use[f] <= 1'b1;
							s_name[f] <= sname;
							s_len[f] <= slen;
							s_cnt[f] <= ann;
						end
						sess <= 1'b0;
					end
					MSG_ERROR: begin
						sess <= 1'b0;
						drop <= 1'b0;
						last_cause_o <= tx_cause_i;
					end
					MSG_QUERY: begin
						if (tx_name_i == NAME_CURRENT && tx_name_len_i == NAME_CUR_LEN) reply(AIR);
						else if (tx_name_i == NAME_NEXT && tx_name_len_i == NAME_NEXT_LEN) begin
							if (pending_i) reply(AIR);
							else put(MSG_ERROR, '0, CAUSE_UNKNOWN);
						end else if (i >= 0) reply(s_cnt[i]);
						else put(MSG_ERROR, '0, CAUSE_UNKNOWN);
					end
					MSG_DELETE: begin
						if (i >= 0) s_use[i] <= 1'b0;
						else put(MSG_ERROR, '0, CAUSE_UNKNOWN);
					end
					default: ;
				endcase
			end
		end
	end
endmodule : csh_dev_model

//--- test/test_config_session_handler.sv
`timescale 1ns/1ps
module test_config_session_handler;
	import csh_pkg::*;
	localparam csh_counts_t AIR = {14'h0000, 14'h0001, 14'h0001, 14'h0002, 14'h0003};
	localparam logic [31:0] CFG1 = 32'h31474643;
	localparam logic [31:0] SM = 32'h00001F0F;
	localparam logic [31:0] EM = 32'h00001F0D;
	localparam logic [7:0] RST_A [8] = '{REG_CTRL, REG_STATUS, REG_NAME0, REG_NAME_LEN,
		REG_COUNT0, REG_RX_COUNT0, REG_END, 8'h05};
	localparam logic [31:0] BN0 [4] = '{NAME_CURRENT[31:0], NAME_NEXT, CFG1, CFG1};
	localparam logic [31:0] BN1 [4] = '{{8'h00, NAME_CURRENT[55:32]}, 32'h0, 32'h0, 32'h0};
	localparam logic [4:0] BL [4] = '{NAME_CUR_LEN, NAME_NEXT_LEN, 5'h00, 5'h11};
	localparam csh_cause_t FC [4] = '{CAUSE_NONE, CAUSE_TIMEOUT, CAUSE_CNT_SUB, CAUSE_ORDER};
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic tx_valid_o, tx_ready_i, rx_valid_i, mdl_bad;
	csh_msg_t tx_type_o, rx_type_i;
	logic [NAME_W-1:0] tx_name_o;
	logic [4:0] tx_name_len_o;
	csh_counts_t tx_counts_o, rx_counts_i;
	csh_cause_t tx_cause_o, rx_cause_i, last_cause;
	logic [1:0] mode = 2'h0;
	logic slow = 1'b0;
	logic pending = 1'b0;
	logic [2:0] n_stored;
	logic [15:0] n_fire;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;

	always #2.5 clk_i = ~clk_i;

	csh_host_ctrl #(.REPLY_WAIT(50)) uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_valid_o(tx_valid_o),
		.tx_type_o(tx_type_o), .tx_name_o(tx_name_o), .tx_name_len_o(tx_name_len_o),
		.tx_counts_o(tx_counts_o), .tx_cause_o(tx_cause_o), .tx_ready_i(tx_ready_i),
		.rx_valid_i(rx_valid_i), .rx_type_i(rx_type_i), .rx_counts_i(rx_counts_i),
		.rx_cause_i(rx_cause_i));

	csh_dev_model #(.AIR(AIR)) mdl (.clk_i(clk_i), .reset_i(reset_i), .tx_valid_i(tx_valid_o),
		.tx_type_i(tx_type_o), .tx_name_i(tx_name_o), .tx_name_len_i(tx_name_len_o),
		.tx_counts_i(tx_counts_o), .tx_cause_i(tx_cause_o), .tx_ready_o(tx_ready_i),
		.rx_valid_o(rx_valid_i), .rx_type_o(rx_type_i), .rx_counts_o(rx_counts_i),
		.rx_cause_o(rx_cause_i), .mode_i(mode), .slow_i(slow), .pending_i(pending),
		.bad_o(mdl_bad), .n_stored_o(n_stored), .last_cause_o(last_cause), .n_fire_o(n_fire));

	// Prints the counts and the verdict, then stops
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// Read data stand in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	// Reads status until the masked bits match, with a bounded count
	task automatic poll(input logic [31:0] exp, input logic [31:0] mask, output logic [31:0] st);
		st = '1;
		for (int i = 0; i < 400 && (st & mask) !== exp; i++) rd(REG_STATUS, st);
	endtask : poll

	task automatic set_cfg(input logic [31:0] n0, input logic [31:0] n1, input logic [4:0] len,
		input csh_counts_t c);
		wr(REG_NAME0, n0);
		wr(REG_NAME0 + 8'h04, n1);
		wr(REG_NAME_LEN, {27'h0, len});
		for (int k = 0; k < NCAT; k++) wr(REG_COUNT0 + 8'(4 * k), {18'h0, c[k]});
	endtask : set_cfg

	task automatic run(input logic [1:0] c, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] st;
		wr(REG_CTRL, {30'h0, c});
		poll(exp, mask, st);
		chk(st & mask, exp, "status");
	endtask : run

	function automatic logic [31:0] ev(input csh_cause_t c);
		return {19'h0, c, 8'h04};
	endfunction : ev

	initial begin : main
		logic [31:0] v;
		csh_counts_t c;
		logic [15:0] f;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			rd(RST_A[k], v);
			chk(v, 32'h0, "reset value");
		end
		$display("test reset done");
		slow <= 1'b1;
		set_cfg(CFG1, 32'h0, 5'h04, {5{14'h0001}});
		run(CMD_CREATE, 32'h2, SM);
		chk(32'(n_stored), 32'h1, "stored");
		run(CMD_CREATE, ev(CAUSE_USED), EM);
		chk(32'(n_stored), 32'h1, "stored");
		f = n_fire;
		for (int k = 0; k < 4; k++) begin
			set_cfg(BN0[k], BN1[k], BL[k], '0);
			run(CMD_CREATE, ev(CAUSE_LOC_NAME), EM);
		end
		for (int k = 0; k < NCAT; k++) begin
			c = '0;
			c[k] = CNT_MAX[k] + 14'h0001;
			set_cfg(CFG1 + 32'h1, 32'h0, 5'h04, c);
			run(CMD_CREATE, ev(CAUSE_LOC_COUNT), EM);
		end
		chk(32'(n_fire), 32'(f), "nothing sent");
		c = '0;
		c[0] = CNT_MAX[0];
		c[4] = CNT_MAX[4];
		slow <= 1'b0;
		set_cfg(CFG1 + 32'h1, 32'h0, 5'h04, c);
		run(CMD_CREATE, 32'h2, SM);
		chk(32'(n_stored), 32'h2, "stored");
		chk(32'(mdl_bad), 32'h0, "order on wire");
		$display("test create done");
		set_cfg(CFG1, 32'h0, 5'h04, '0);
		run(CMD_QUERY, 32'hA, SM);
		for (int k = 0; k < NCAT; k++) begin
			rd(REG_RX_COUNT0 + 8'(4 * k), v);
			chk(v, 32'h1, "rx count");
		end
		set_cfg(BN0[0], BN1[0], BL[0], '0);
		run(CMD_QUERY, 32'hA, SM);
		for (int k = 0; k < NCAT; k++) begin
			rd(REG_RX_COUNT0 + 8'(4 * k), v);
			chk(v, {18'h0, AIR[k]}, "on-air count");
		end
		set_cfg(BN0[1], BN1[1], BL[1], '0);
		run(CMD_QUERY, ev(CAUSE_UNKNOWN), EM);
		pending <= 1'b1;
		run(CMD_QUERY, 32'hA, SM);
		set_cfg(CFG1, 32'h0, 5'h04, '0);
		for (int m = 1; m < 4; m++) begin
			mode <= 2'(m);
			run(CMD_QUERY, ev(FC[m]), EM);
			if (m > 1) chk(32'(last_cause), 32'(FC[m]), "error sent");
		end
		mode <= 2'h0;
		$display("test query done");
		run(CMD_DELETE, 32'h2, SM);
		chk(32'(n_stored), 32'h1, "stored");
		run(CMD_DELETE, ev(CAUSE_UNKNOWN), EM);
		$display("test delete done");
		slow <= 1'b1;
		c = '0;
		c[0] = 14'h0008;
		set_cfg(CFG1 + 32'h2, 32'h0, 5'h04, c);
		wr(REG_CTRL, {30'h0, CMD_CREATE});
		poll(32'h00020000, 32'h00070000, v);
		wr(REG_CTRL, 32'h1 << CTRL_ABORT_BIT);
		poll(ev(CAUSE_PROTO), EM, v);
		chk(v & EM, ev(CAUSE_PROTO), "abort status");
		chk(32'(last_cause), 32'(CAUSE_PROTO), "abort sent");
		chk(32'(n_stored), 32'h1, "stored");
		$display("test abort done");
		test_done();
	end
endmodule : test_config_session_handler
